// File: verilog/pos_map.vh
// Purpose: offsets, field positions, reset values and codes of the output steering block
// Assumes: 32-bit AHB-Lite slave, one aligned word per register
// Notes: definitions only
`ifndef POS_MAP_VH
`define POS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define POS_ADDR_CTRL 8'h00
`define POS_ADDR_STEER_SEL 8'h04
`define POS_ADDR_STEER_OPT 8'h08
`define POS_ADDR_BURST 8'h0C
`define POS_ADDR_SD_CTRL 8'h10
`define POS_ADDR_SD_SRC 8'h14
`define POS_ADDR_SD_LEVEL 8'h18
`define POS_ADDR_DB_RISE 8'h1C
`define POS_ADDR_DB_FALL 8'h20
`define POS_ADDR_STATUS 8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define POS_CTRL_ENABLE 0
`define POS_CTRL_LOAD 1
`define POS_CTRL_MODE_LO 2
`define POS_CTRL_MODE_HI 3
`define POS_CTRL_DBR_EN 4
`define POS_CTRL_DBF_EN 5
`define POS_OPT_SYNC 0
`define POS_BURST_SEL_LO 0
`define POS_BURST_SEL_HI 3
`define POS_BURST_SOFT 6
`define POS_BURST_EN 7
`define POS_SD_OVERRIDE 3
`define POS_SD_RESTART 4
`define POS_SD_ACTIVE 5
`define POS_SD_EVENT 6
`define POS_SD_EN 7

// ----------------------------------------
// mode codes and reset values
// ----------------------------------------
`define POS_MODE_SINGLE 2'h0
`define POS_MODE_COMPL 2'h1
`define POS_MODE_3PH 2'h2
`define POS_MODE_FIXED 2'h3
`define POS_BURST_SEL_SOFT 4'h8
`define POS_RST_BYTE 8'h00
`define POS_RST_WORD 32'h0000_0000
`define POS_HTRANS_NONSEQ 2'h2

`endif

// File: verilog/pos_steer.v
// Purpose: dead-band overlap handling, output steering, burst gating and auto-shutdown
// Assumes: rise/fall/period events are one-cycle pulses on clk from the pwm core
// Notes: all inputs except rst synchronous to clk; AHB-Lite slave with zero wait states
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`include "pos_map.vh"

module pos_steer (
   input wire clk, // 25 MHz module clock
   input wire rst, // asynchronous, active high
   input wire hsel, // slave select
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write strobe of address phase
   input wire [2:0] hsize, // transfer size, word only
   input wire [31:0] hwdata, // write data
   input wire hready, // bus ready
   output wire hreadyout, // always ready
   output reg [31:0] hrdata, // read data
   output wire hresp, // always okay
   input wire periodEvent, // period event pulse from core
   input wire risingEvent, // rising edge event pulse
   input wire fallingEvent, // falling edge event pulse
   input wire externalEventPin, // dedicated input pin
   input wire [2:0] capUnitOut, // capture_compare_unit outputs
   input wire [3:0] cmpOut, // comparator outputs
   output reg outA, // steered pwm pins
   output reg outB,
   output reg outC,
   output reg outD,
   output reg outE,
   output reg outF,
   output reg periodRestart, // asks core for a new period
   output reg pwmRunning, // core may run when high
   output reg shutdownIrq // one-cycle auto-shutdown interrupt
);

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   reg [5:0] ctrl;
   reg [5:0] steerSel;
   reg syncBit;
   reg [7:0] burstCtrl;
   reg enable;
   reg loadPending;
   reg [5:0] syncBuf;
   reg [5:0] activeSteer;
   reg sdEnable;
   reg sdEvent;
   reg sdActive;
   reg sdRestart;
   reg pinOverride;
   reg sdHold;
   reg [7:0] sdSrcMask;
   reg [5:0] sdLevel;
   reg [7:0] dbRise;
   reg [7:0] dbFall;
   reg [7:0] riseCnt;
   reg [7:0] fallCnt;
   reg riseBusy;
   reg fallBusy;
   reg freeze;
   reg pwmRaw;
   reg primLvl;
   reg compLvl;
   reg burstPrev;
   reg stopPending;
   reg wrPend;
   reg [7:0] wrAddr;
   wire [1:0] mode;
   wire [7:0] srcVec;
   wire burstSrc;
   wire srcHit;
   wire sdCond;
   wire addrOk;
   wire wrNow;
   wire riseEv;
   wire fallEv;
   wire [5:0] steerNow;
   reg [5:0] next_pins;
   reg [5:0] phasePins;
   reg [31:0] next_rdata;

   assign mode = ctrl[`POS_CTRL_MODE_HI:`POS_CTRL_MODE_LO];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------
   // bus access
   // ----------------------------------------
   // address phase accepted on the rising edge, write committed one cycle later
   assign addrOk = hsel && hready && (htrans == `POS_HTRANS_NONSEQ);
   assign wrNow = wrPend;

   // latch the write address and build read data in the address phase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPend <= 1'b0;
         wrAddr <= `POS_RST_BYTE;
         hrdata <= `POS_RST_WORD;
      end else begin
         // writes outside the map are dropped, matching the read decode
         wrPend <= addrOk && hwrite && (haddr[31:8] == 24'h00_0000);
         wrAddr <= haddr[7:0];
         if (addrOk && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   // read mux; unmapped addresses and bits above a field read zero
   always @* begin
      next_rdata = `POS_RST_WORD;
      if (haddr[31:8] == 24'h00_0000) begin
         case (haddr[7:0])
            `POS_ADDR_CTRL: next_rdata = {26'h000_0000, ctrl[5:2], loadPending, enable};
            `POS_ADDR_STEER_SEL: next_rdata = {26'h000_0000, steerSel};
            `POS_ADDR_STEER_OPT: next_rdata = {31'h0000_0000, syncBit};
            `POS_ADDR_BURST: next_rdata = {24'h00_0000, burstCtrl};
            `POS_ADDR_SD_CTRL: next_rdata = {24'h00_0000, sdEnable, sdEvent, sdActive,
               sdRestart, pinOverride, 3'h0};
            `POS_ADDR_SD_SRC: next_rdata = {24'h00_0000, sdSrcMask};
            `POS_ADDR_SD_LEVEL: next_rdata = {26'h000_0000, sdLevel};
            `POS_ADDR_DB_RISE: next_rdata = {24'h00_0000, dbRise};
            `POS_ADDR_DB_FALL: next_rdata = {24'h00_0000, dbFall};
            `POS_ADDR_STATUS: next_rdata = {20'h0_0000, activeSteer, pwmRunning,
               sdHold, riseBusy, fallBusy, freeze, pwmRaw};
            default: next_rdata = `POS_RST_WORD;
         endcase
      end
   end

   // ----------------------------------------
   // configuration and steering buffer
   // ----------------------------------------
   // hardware-driven bits sit in this process too, so each has one driver
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= 6'h00;
         enable <= 1'b0;
         loadPending <= 1'b0;
         steerSel <= 6'h00;
         syncBit <= 1'b0;
         syncBuf <= 6'h00;
         activeSteer <= 6'h00;
         burstCtrl <= `POS_RST_BYTE;
         sdEnable <= 1'b0;
         sdEvent <= 1'b0;
         sdActive <= 1'b0;
         sdRestart <= 1'b0;
         pinOverride <= 1'b0;
         sdSrcMask <= `POS_RST_BYTE;
         sdLevel <= 6'h00;
         dbRise <= `POS_RST_BYTE;
         dbFall <= `POS_RST_BYTE;
      end else begin
         if (loadPending && periodEvent) begin
            activeSteer <= syncBuf;
            loadPending <= 1'b0;
         end
         if (wrNow) begin
            case (wrAddr)
               `POS_ADDR_CTRL: begin
                  ctrl <= hwdata[5:0];
                  enable <= hwdata[`POS_CTRL_ENABLE];
                  if ((hwdata[`POS_CTRL_ENABLE] && !enable) || hwdata[`POS_CTRL_LOAD]) begin
                     syncBuf <= steerSel;
                     loadPending <= 1'b1;
                  end
               end
               `POS_ADDR_STEER_SEL: steerSel <= hwdata[5:0];
               `POS_ADDR_STEER_OPT: begin
                  syncBit <= hwdata[`POS_OPT_SYNC];
                  if (hwdata[`POS_OPT_SYNC] && !syncBit) begin
                     activeSteer <= syncBuf;
                  end
               end
               `POS_ADDR_BURST: burstCtrl <= hwdata[7:0];
               `POS_ADDR_SD_CTRL: begin
                  sdEnable <= hwdata[`POS_SD_EN];
                  sdRestart <= hwdata[`POS_SD_RESTART];
                  pinOverride <= hwdata[`POS_SD_OVERRIDE];
                  sdEvent <= hwdata[`POS_SD_EVENT];
                  if (!hwdata[`POS_SD_ACTIVE] && !sdCond) begin
                     sdActive <= 1'b0;
                  end
               end
               `POS_ADDR_SD_SRC: sdSrcMask <= hwdata[7:0];
               `POS_ADDR_SD_LEVEL: sdLevel <= hwdata[5:0];
               `POS_ADDR_DB_RISE: dbRise <= hwdata[7:0];
               `POS_ADDR_DB_FALL: dbFall <= hwdata[7:0];
               default: ;
            endcase
         end
         // source hit sets event bit; set beats a software clear
         if (srcHit) begin
            sdEvent <= 1'b1;
         end
         // flag held until cleared; auto restart clears it
         if (sdCond) begin
            sdActive <= 1'b1;
         end else if (sdRestart) begin
            sdActive <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // shutdown condition
   // ----------------------------------------
   assign srcVec = {cmpOut, capUnitOut, externalEventPin};
   // one enable gates everything; plain level, no edge detect
   assign srcHit = sdEnable && ((srcVec & sdSrcMask) != 8'h00);
   assign sdCond = sdEnable && (sdEvent || srcHit);

   // override held until a period event after the flag has cleared
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sdHold <= 1'b0;
         shutdownIrq <= 1'b0;
      end else begin
         if (sdCond || sdActive) begin
            sdHold <= 1'b1;
         end else if (periodEvent) begin
            sdHold <= 1'b0;
         end
         // interrupt on a new shutdown event
         shutdownIrq <= sdCond && !sdHold;
      end
   end

   // ----------------------------------------
   // burst modulation
   // ----------------------------------------
   // single source, soft bit as last choice
   assign burstSrc = (burstCtrl[`POS_BURST_SEL_HI:`POS_BURST_SEL_LO] >= `POS_BURST_SEL_SOFT) ?
      burstCtrl[`POS_BURST_SOFT] : srcVec[burstCtrl[2:0]];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pwmRunning <= 1'b0;
         periodRestart <= 1'b0;
         burstPrev <= 1'b0;
         stopPending <= 1'b0;
      end else begin
         burstPrev <= burstSrc;
         periodRestart <= 1'b0;
         if (!enable) begin
            pwmRunning <= 1'b0;
            stopPending <= 1'b0;
         end else if (!burstCtrl[`POS_BURST_EN]) begin
            pwmRunning <= 1'b1;
            stopPending <= 1'b0;
         end else if (burstSrc && !pwmRunning) begin
            pwmRunning <= 1'b1;
            periodRestart <= 1'b1;
            stopPending <= 1'b0;
         end else if (burstSrc) begin
            stopPending <= 1'b0;
         end else if (pwmRunning) begin
            stopPending <= 1'b1;
            if (stopPending && periodEvent) begin
               // fixed duty waits for a period event with the raw pwm output high
               if (mode != `POS_MODE_FIXED || pwmRaw) begin
                  pwmRunning <= 1'b0;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // dead-band counters
   // ----------------------------------------
   assign riseEv = risingEvent && pwmRunning;
   assign fallEv = fallingEvent && pwmRunning;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         riseCnt <= `POS_RST_BYTE;
         fallCnt <= `POS_RST_BYTE;
         riseBusy <= 1'b0;
         fallBusy <= 1'b0;
         freeze <= 1'b0;
         pwmRaw <= 1'b0;
      end else if (!pwmRunning) begin
         riseBusy <= 1'b0;
         fallBusy <= 1'b0;
         freeze <= 1'b0;
         pwmRaw <= 1'b0;
      end else begin
         if (riseBusy) begin
            riseCnt <= riseCnt + 8'h01;
            if (riseCnt + 8'h01 >= dbRise) begin
               riseBusy <= 1'b0;
               freeze <= 1'b0;
            end
         end
         if (fallBusy) begin
            fallCnt <= fallCnt + 8'h01;
            if (fallCnt + 8'h01 >= dbFall) begin
               fallBusy <= 1'b0;
               freeze <= 1'b0;
            end
         end
         if (riseEv) begin
            pwmRaw <= 1'b1;
            fallBusy <= 1'b0;
            riseCnt <= `POS_RST_BYTE;
            riseBusy <= ctrl[`POS_CTRL_DBR_EN] && (dbRise != `POS_RST_BYTE);
            freeze <= riseBusy;
         end else if (fallEv) begin
            pwmRaw <= 1'b0;
            riseBusy <= 1'b0;
            fallCnt <= `POS_RST_BYTE;
            fallBusy <= ctrl[`POS_CTRL_DBF_EN] && (dbFall != `POS_RST_BYTE);
            freeze <= fallBusy;
         end
      end
   end

   // primary waits out rise dead-band, complement waits out fall dead-band
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         primLvl <= 1'b0;
         compLvl <= 1'b0;
      end else if (!pwmRunning) begin
         primLvl <= 1'b0;
         compLvl <= 1'b0;
      end else if (!freeze) begin
         primLvl <= pwmRaw && !riseBusy;
         compLvl <= !pwmRaw && !fallBusy;
      end
   end

   // ----------------------------------------
   // steering and pin drive
   // ----------------------------------------
   // unsynced selection acts at once
   assign steerNow = syncBit ? activeSteer : steerSel;

   // 3-phase pairs; lowest set bit wins so a stray pattern stays a legal pair
   always @* begin
      phasePins = 6'h00;
      if (steerNow[0]) begin
         phasePins = 6'h09;
      end else if (steerNow[1]) begin
         phasePins = 6'h21;
      end else if (steerNow[2]) begin
         phasePins = 6'h24;
      end else if (steerNow[3]) begin
         phasePins = 6'h06;
      end else if (steerNow[4]) begin
         phasePins = 6'h12;
      end else if (steerNow[5]) begin
         phasePins = 6'h18;
      end
   end

   // pin order is {F,E,D,C,B,A}
   always @* begin
      next_pins = 6'h00;
      case (mode)
         `POS_MODE_SINGLE: next_pins = steerNow & {6{primLvl}};
         `POS_MODE_COMPL: begin
            next_pins[0] = steerNow[0] && primLvl;
            next_pins[1] = steerNow[1] && compLvl;
            next_pins[2] = steerNow[2] && primLvl;
            next_pins[3] = steerNow[3] && compLvl;
            next_pins[4] = (steerNow[4] && primLvl) || (steerNow[5] && compLvl);
         end
         `POS_MODE_3PH: next_pins = phasePins & {6{primLvl}};
         `POS_MODE_FIXED: next_pins = {4'h0, compLvl, primLvl};
         default: next_pins = 6'h00;
      endcase
      // shutdown levels win; override without interrupt
      if (sdHold || (sdEnable && pinOverride)) begin
         next_pins = sdLevel;
      end
   end

   // pins registered so glitches of the steering mux never reach the switches
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {outF, outE, outD, outC, outB, outA} <= 6'h00;
      end else begin
         {outF, outE, outD, outC, outB, outA} <= next_pins;
      end
   end

endmodule

// File: verif/pos_steer_assertions.sv
// Purpose: concurrent checks on the pin, status and bus ports of the steering block
// Assumes: software writes are mirrored from the bus, hardware-set bits are not seen
// Notes: the mirror covers shutdown control, source mask and pin levels only
`include "pos_map.vh"
module pos_steer_assertions (
   input wire clk, // module clock
   input wire rst, // async reset, active high
   input wire hsel, // slave select
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write flag
   input wire [31:0] hwdata, // write data
   input wire hready, // bus ready
   input wire hreadyout, // slave ready
   input wire hresp, // slave response
   input wire externalEventPin, // source 0
   input wire [2:0] capUnitOut, // sources 1 to 3
   input wire [3:0] cmpOut, // sources 4 to 7
   input wire outA, // pin a
   input wire outB, // pin b
   input wire outC, // pin c
   input wire outD, // pin d
   input wire outE, // pin e
   input wire outF, // pin f
   input wire periodRestart, // new period request
   input wire pwmRunning, // core may run
   input wire shutdownIrq // shutdown interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   reg wrPend;
   reg [7:0] wrAddr;
   reg [7:0] sdc;
   reg [7:0] mask;
   reg [7:0] lvl;
   wire [7:0] srcVec = {cmpOut, capUnitOut, externalEventPin};
   wire [5:0] pins = {outF, outE, outD, outC, outB, outA};
   // ----------------------------------------
   // register mirror
   // ----------------------------------------
   // a write lands at the end of its data phase, the same edge the slave commits it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         sdc <= 8'h00;
         mask <= 8'h00;
         lvl <= 8'h00;
      end else begin
         if (hready) begin
            wrPend <= hsel && hwrite && (htrans == `POS_HTRANS_NONSEQ);
            wrAddr <= haddr[7:0];
         end
         if (wrPend && hready && wrAddr == `POS_ADDR_SD_CTRL) sdc <= hwdata[7:0];
         if (wrPend && hready && wrAddr == `POS_ADDR_SD_SRC) mask <= hwdata[7:0];
         if (wrPend && hready && wrAddr == `POS_ADDR_SD_LEVEL) lvl <= hwdata[7:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // three cycles of a live shutdown cause: one to register, one to reach the pins
   sequence sdHeld;
      (sdc[7] && (sdc[6] || (mask & srcVec) != 8'h00))[*3];
   endsequence
   sequence ovrHeld;
      (sdc[7] && sdc[3])[*3];
   endsequence
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   sd_levels_a: assert property (sdHeld |-> pins == lvl[5:0])
      else $error("pins not at shutdown levels");
   irq_pulse_a: assert property (shutdownIrq |=> !shutdownIrq)
      else $error("shutdown interrupt longer than one cycle");
   irq_gated_a: assert property ((!sdc[7])[*3] |-> !shutdownIrq)
      else $error("interrupt while shutdown disabled");
   override_levels_a: assert property (ovrHeld |-> pins == lvl[5:0])
      else $error("override did not force levels");
   override_quiet_a: assert property
      ((sdc[7] && sdc[3] && !sdc[6] && (mask & srcVec) == 8'h00)[*3] |-> !shutdownIrq)
      else $error("override raised an interrupt");
   restart_once_a: assert property (periodRestart |=> !periodRestart)
      else $error("period restart longer than one cycle");
   freeze_idle_a: assert property
      ($fell(pwmRunning) && !sdc[7] |-> ##[0:3] pins == 6'h00)
      else $error("pins not idle after freeze");
endmodule

// File: verif/pos_switch_model.sv
// Purpose: behavioural model of the six external power switch drivers
// Assumes: pins are active high gate commands
// Notes: conduction lags the command by one clock, as a real gate driver does
module pos_switch_model (
   input wire clk, // module clock
   input wire rst, // async reset, active high
   input wire [5:0] gateCmd, // gate commands f..a
   output reg [5:0] swState // conduction state f..a
);
   timeunit 1ns;
   timeprecision 1ps;
   // the bench reads the switches, not the pins, so any pin glitch is seen late
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         swState <= 6'h00;
      end else begin
         swState <= gateCmd;
      end
   end
endmodule

// File: verif/test_pos_steer.sv
// Purpose: directed test of steering, dead band, shutdown and burst gating
// Assumes: zero wait state slave; pins are judged through the switch model
// Notes: pin latencies are waited out with margin, dead-band lengths are measured
`include "pos_map.vh"
module test_pos_steer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [2:0] ev = 3'h0; // period, rising, falling
   logic [7:0] src = 8'h00; // comparators, capture units, pin
   wire hreadyout, hresp, outA, outB, outC, outD, outE, outF;
   wire periodRestart, pwmRunning, shutdownIrq;
   wire [31:0] hrdata;
   wire [5:0] swState;
   logic [31:0] q;
   int fails = 0;
   int cmp_count = 0;
   int irqCnt = 0;
   int rstCnt = 0;
   int n1, n2, n3;
   localparam logic [5:0] PH_PINS [0:5] = '{6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};
   always #20 clk = ~clk;
   pos_steer u_pos_steer (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .periodEvent(ev[2]),
      .risingEvent(ev[1]), .fallingEvent(ev[0]), .externalEventPin(src[0]),
      .capUnitOut(src[3:1]), .cmpOut(src[7:4]), .outA(outA), .outB(outB), .outC(outC),
      .outD(outD), .outE(outE), .outF(outF), .periodRestart(periodRestart),
      .pwmRunning(pwmRunning), .shutdownIrq(shutdownIrq));
   pos_switch_model u_pos_switch_model (.clk(clk), .rst(rst),
      .gateCmd({outF, outE, outD, outC, outB, outA}), .swState(swState));
   // pulses are counted so that one-shot outputs can be compared as totals
   always @(posedge clk) begin
      irqCnt <= irqCnt + int'(shutdownIrq === 1'b1);
      rstCnt <= rstCnt + int'(periodRestart === 1'b1);
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer; each phase is held until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= `POS_HTRANS_NONSEQ;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      bus(1'b0, a, 8'h00);
      chk(q & {24'h00_0000, m}, {24'h00_0000, e});
   endtask
   task automatic ckPins(input logic [5:0] e);
      waitc(5);
      chk(32'(swState), 32'(e));
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask
   // cycles from a rising event until the primary switch conducts
   task automatic lat(output int n);
      pulse(1);
      n = 0;
      while (swState[0] !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask
   // opposite edge five cycles into a count; the suppressed switch must never conduct
   task automatic overlap(input int first, input int pin, output int n);
      pulse(first);
      waitc(3);
      pulse(1 - first);
      n = 0;
      repeat (25) begin
         @(posedge clk);
         n += int'(swState[pin] === 1'b1);
      end
   endtask
   task automatic print_verdict;
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // the whole sequence needs well under two thousand cycles
   initial begin
      waitc(20000);
      fails++;
      $display("mismatch at %0t: watchdog ran out", $time);
      print_verdict;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      waitc(12);
      rst <= 1'b0;
      rd(`POS_ADDR_CTRL, 8'h00, 8'hFF);
      rd(`POS_ADDR_STATUS, 8'h00, 8'hFF);
      rd(8'h40, 8'h00, 8'hFF);
      ckPins(6'h00);
      $display("test reset done");
      wr(`POS_ADDR_STEER_SEL, 8'h2D);
      wr(`POS_ADDR_CTRL, 8'h01);
      waitc(2);
      chk(32'(pwmRunning), 32'h1);
      pulse(1);
      ckPins(6'h2D);
      pulse(0);
      ckPins(6'h00);
      wr(`POS_ADDR_CTRL, 8'h05);
      wr(`POS_ADDR_STEER_SEL, 8'h0F);
      pulse(1);
      ckPins(6'h05);
      pulse(0);
      ckPins(6'h0A);
      $display("test single and complementary done");
      wr(`POS_ADDR_CTRL, 8'h09);
      pulse(1);
      for (int i = 0; i < 6; i++) begin
         wr(`POS_ADDR_STEER_SEL, 8'h01 << i);
         ckPins(PH_PINS[i]);
      end
      wr(`POS_ADDR_STEER_SEL, 8'h06);
      ckPins(PH_PINS[1]);
      $display("test three phase done");
      wr(`POS_ADDR_CTRL, 8'h01);
      pulse(1);
      wr(`POS_ADDR_STEER_SEL, 8'h01);
      ckPins(6'h01);
      wr(`POS_ADDR_CTRL, 8'h03);
      wr(`POS_ADDR_STEER_SEL, 8'h02);
      ckPins(6'h02);
      wr(`POS_ADDR_STEER_OPT, 8'h01);
      ckPins(6'h01);
      wr(`POS_ADDR_STEER_SEL, 8'h04);
      wr(`POS_ADDR_CTRL, 8'h03);
      ckPins(6'h01);
      pulse(2);
      pulse(1);
      ckPins(6'h04);
      wr(`POS_ADDR_STEER_OPT, 8'h00);
      $display("test synchronised steering done");
      wr(`POS_ADDR_DB_RISE, 8'h0A);
      wr(`POS_ADDR_DB_FALL, 8'h0A);
      wr(`POS_ADDR_STEER_SEL, 8'h03);
      wr(`POS_ADDR_CTRL, 8'h35);
      pulse(0);
      waitc(20);
      overlap(1, 0, n1);
      chk(32'(n1), 32'h0);
      ckPins(6'h02);
      overlap(0, 1, n1);
      chk(32'(n1), 32'h0);
      ckPins(6'h01);
      pulse(0);
      waitc(20);
      lat(n1);
      pulse(0);
      waitc(20);
      pulse(1);
      waitc(4);
      lat(n3);
      chk(32'(n3), 32'(n1));
      pulse(0);
      waitc(20);
      wr(`POS_ADDR_DB_RISE, 8'h04);
      wr(`POS_ADDR_CTRL, 8'h37);
      pulse(2);
      lat(n2);
      chk(32'(n1 - n2), 32'h6);
      $display("test dead band done");
      wr(`POS_ADDR_SD_LEVEL, 8'h33);
      wr(`POS_ADDR_SD_CTRL, 8'hC0);
      ckPins(6'h33);
      rd(`POS_ADDR_SD_CTRL, 8'h20, 8'h20);
      wr(`POS_ADDR_SD_CTRL, 8'hA0);
      pulse(2);
      ckPins(6'h33);
      wr(`POS_ADDR_SD_CTRL, 8'h80);
      ckPins(6'h33);
      pulse(2);
      ckPins(6'h01);
      wr(`POS_ADDR_SD_SRC, 8'h01);
      wr(`POS_ADDR_SD_CTRL, 8'h90);
      n1 = irqCnt;
      src <= 8'h01;
      ckPins(6'h33);
      waitc(20);
      chk(32'(irqCnt - n1), 32'h1);
      rd(`POS_ADDR_SD_CTRL, 8'h60, 8'h60);
      wr(`POS_ADDR_SD_CTRL, 8'h90);
      rd(`POS_ADDR_SD_CTRL, 8'h20, 8'h20);
      ckPins(6'h33);
      src <= 8'h00;
      wr(`POS_ADDR_SD_CTRL, 8'h90);
      waitc(3);
      rd(`POS_ADDR_SD_CTRL, 8'h00, 8'h60);
      pulse(2);
      ckPins(6'h01);
      wr(`POS_ADDR_SD_CTRL, 8'h00);
      n1 = irqCnt;
      src <= 8'h01;
      ckPins(6'h01);
      chk(32'(irqCnt - n1), 32'h0);
      src <= 8'h00;
      wr(`POS_ADDR_SD_CTRL, 8'h88);
      ckPins(6'h33);
      chk(32'(irqCnt - n1), 32'h0);
      wr(`POS_ADDR_SD_CTRL, 8'h00);
      pulse(2);
      ckPins(6'h01);
      $display("test shutdown done");
      for (int s = 0; s < 9; s++) begin
         src <= 8'h00;
         wr(`POS_ADDR_BURST, (s < 8) ? 8'h80 | 8'(s) : 8'h88);
         pulse(2);
         waitc(3);
         chk(32'(pwmRunning), 32'h0);
         ckPins(6'h00);
         n1 = rstCnt;
         if (s < 8) src <= 8'h01 << s;
         else wr(`POS_ADDR_BURST, 8'hC8);
         waitc(5);
         chk(32'(pwmRunning), 32'h1);
         chk(32'(rstCnt - n1), 32'h1);
      end
      wr(`POS_ADDR_CTRL, 8'h0D);
      pulse(0);
      wr(`POS_ADDR_BURST, 8'h88);
      pulse(2);
      waitc(3);
      chk(32'(pwmRunning), 32'h1);
      pulse(1);
      pulse(2);
      waitc(3);
      chk(32'(pwmRunning), 32'h0);
      ckPins(6'h00);
      src <= 8'h00;
      wr(`POS_ADDR_BURST, 8'h08);
      pulse(2);
      waitc(3);
      chk(32'(pwmRunning), 32'h1);
      $display("test burst done");
      print_verdict;
   end
endmodule
bind pos_steer pos_steer_assertions u_pos_steer_assertions (.clk, .rst, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .externalEventPin, .capUnitOut,
   .cmpOut, .outA, .outB, .outC, .outD, .outE, .outF, .periodRestart, .pwmRunning,
   .shutdownIrq);
